// >>> rtl/spw_device.sv
// Device end: power-up standby, write-arm latch and write-commit guard of a serial EEPROM.
// Assumes the link pins are asynchronous to clk_in and slow enough for two-flop sampling.
`timescale 1ns/1ps

module spw_device #(
    parameter int unsigned WC_CYCLES = spw_pkg::WC_CYCLES
) (
    // Clock, reset and enable
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic ce_in,
    // Serial link
    spw_link_if.device link,
    // Status toward the user side
    output logic      write_busy_out,
    output logic      write_armed_out,
    output logic      standby_out,
    output logic      write_start_out
);
    import spw_pkg::*;

    localparam int unsigned WCW = $clog2(WC_CYCLES + 1);

    if (WC_CYCLES < 2) begin : g_bad_wc
        $error("WC_CYCLES must be at least 2");
    end

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] hist;
    wire  [2:0] pins = {link.cs_n, link.sck, link.si};

    // Resetting the chip-select samples to low means a select held low across reset shows no
    // falling edge, so the device keeps waiting for a fresh one.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
            hist  <= SYNC_RST;
        end else if (ce_in) begin
            sync1 <= pins;
            sync2 <= sync1;
            hist  <= sync2;
        end
    end

    wire cs_fall  = hist[2] & ~sync2[2];
    wire cs_rise  = ~hist[2] & sync2[2];
    wire sck_rise = ~hist[1] & sync2[1];
    wire sck_fall = hist[1] & ~sync2[1];
    wire si_bit   = sync2[0];

    // ----------------------------------------------------------------
    // State and decode
    // ----------------------------------------------------------------
    spw_dev_state_t state;
    spw_dev_state_t next_state;
    logic [2:0]     bit_cnt;
    logic [2:0]     byte_cnt;
    logic [7:0]     shreg;
    logic [7:0]     opcode;
    logic [7:0]     stat_sr;
    logic           so;
    logic           so_oe_n;
    logic           armed;
    logic           busy;
    logic           standby;
    logic           start;
    logic [WCW-1:0] wc_cnt;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_STANDBY: begin
                if (cs_fall) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (cs_rise) begin
                    next_state = ST_STANDBY;
                end
            end
        endcase
    end

    wire       selected    = (state == ST_ACTIVE);
    wire       take_bit    = selected & sck_rise;
    wire [7:0] next_byte   = {shreg[6:0], si_bit};
    wire       byte_done   = take_bit & (bit_cnt == BIT_LAST);
    wire       on_boundary = (bit_cnt == BIT_FIRST);
    wire       end_frame   = selected & cs_rise;
    wire       is_arm      = (opcode == OP_ARM) & (byte_cnt == BYTES_CMD) & on_boundary;
    wire       is_disarm   = (opcode == OP_DISARM) & (byte_cnt == BYTES_CMD) & on_boundary;
    wire       is_page     = (opcode == OP_WRITE) & (byte_cnt >= BYTES_WRITE_MIN) & on_boundary;
    wire       is_stat_wr  = (opcode == OP_WRSR) & (byte_cnt == BYTES_WRSR) & on_boundary;
    wire       commit      = end_frame & armed & ~busy & (is_page | is_stat_wr);
    wire       wc_done     = busy & (wc_cnt == WCW'(WC_CYCLES - 1));
    wire       rdsr_on     = selected & (opcode == OP_RDSR) & (byte_cnt != BYTES_NONE);
    wire [7:0] status_now  = busy ? STAT_BUSY_ALL : (armed ? STAT_ARMED_MASK : STAT_IDLE);

    // ----------------------------------------------------------------
    // Frame reception
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state    <= ST_STANDBY;
            standby  <= 1'b1;
            bit_cnt  <= BIT_FIRST;
            byte_cnt <= BYTES_NONE;
            shreg    <= OP_NONE;
            opcode   <= OP_NONE;
        end else if (ce_in) begin
            state   <= next_state;
            standby <= (next_state == ST_STANDBY);
            if (cs_fall) begin
                bit_cnt  <= BIT_FIRST;
                byte_cnt <= BYTES_NONE;
                opcode   <= OP_NONE;
            end else if (take_bit) begin
                shreg   <= next_byte;
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done && byte_cnt == BYTES_NONE) begin
                    opcode <= next_byte;
                end
                // Page writes roll over, so only the byte boundary matters past the fourth byte.
                if (byte_done && byte_cnt != BYTES_SAT) begin
                    byte_cnt <= byte_cnt + 3'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Arm latch and self-timed write
    // ----------------------------------------------------------------
    // While a write runs every command but the status read is ignored, as the array is not usable.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            armed  <= 1'b0;
            busy   <= 1'b0;
            start  <= 1'b0;
            wc_cnt <= '0;
        end else if (ce_in) begin
            start <= commit;
            if (wc_done) begin
                armed <= 1'b0;
            end else if (end_frame && !busy && is_arm) begin
                armed <= 1'b1;
            end else if (end_frame && !busy && is_disarm) begin
                armed <= 1'b0;
            end
            if (commit) begin
                busy   <= 1'b1;
                wc_cnt <= '0;
            end else if (wc_done) begin
                busy <= 1'b0;
            end else if (busy) begin
                wc_cnt <= wc_cnt + WCW'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Status shift-out
    // ----------------------------------------------------------------
    // Each new byte reloads the live status so a host can poll the busy flag in one frame.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            so      <= 1'b0;
            so_oe_n <= 1'b1;
            stat_sr <= STAT_IDLE;
        end else if (ce_in) begin
            if (!selected || cs_rise) begin
                so_oe_n <= 1'b1;
            end else if (rdsr_on && sck_fall) begin
                so_oe_n <= 1'b0;
                if (on_boundary) begin
                    so      <= status_now[7];
                    stat_sr <= {status_now[6:0], 1'b0};
                end else begin
                    so      <= stat_sr[7];
                    stat_sr <= {stat_sr[6:0], 1'b0};
                end
            end
        end
    end

    assign link.so         = so;
    assign link.so_oe_n    = so_oe_n;
    assign write_busy_out  = busy;
    assign write_armed_out = armed;
    assign standby_out     = standby;
    assign write_start_out = start;
endmodule : spw_device

// >>> rtl/spw_pkg.sv
// Constants, opcodes and state types shared by both ends of the serial EEPROM link.
// Assumes one system clock of 125 MHz on each end.
package spw_pkg;
    // ----------------------------------------------------------------
    // Clock rate
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CLK_KHZ = 125000;

    // ----------------------------------------------------------------
    // Opcodes, sent most significant bit first
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_NONE   = 8'h00;
    localparam logic [7:0] OP_WRSR   = 8'h01;
    localparam logic [7:0] OP_WRITE  = 8'h02;
    localparam logic [7:0] OP_READ   = 8'h03;
    localparam logic [7:0] OP_DISARM = 8'h04;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_ARM    = 8'h06;

    // ----------------------------------------------------------------
    // Frame geometry, counted in bits within a byte and in whole bytes
    // ----------------------------------------------------------------
    localparam logic [2:0] BIT_FIRST       = 3'h0;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [2:0] BYTES_NONE      = 3'h0;
    localparam logic [2:0] BYTES_CMD       = 3'h1;
    localparam logic [2:0] BYTES_WRSR      = 3'h2;
    localparam logic [2:0] BYTES_WRITE_MIN = 3'h4;
    localparam logic [2:0] BYTES_SAT       = 3'h4;

    // ----------------------------------------------------------------
    // Status byte layout
    // ----------------------------------------------------------------
    localparam logic [7:0] STAT_IDLE       = 8'h00;
    localparam logic [7:0] STAT_ARMED_MASK = 8'h02;
    localparam logic [7:0] STAT_BUSY_ALL   = 8'hFF;

    // ----------------------------------------------------------------
    // Timing, figures in their own units, counts derived
    // ----------------------------------------------------------------
    localparam int unsigned T_WC_MS    = 10;
    localparam int unsigned T_PUR_MS   = 1;
    localparam int unsigned T_PUW_MS   = 5;
    localparam int unsigned T_HALF_NS  = 250;
    localparam int unsigned T_LEAD_NS  = 250;
    localparam int unsigned T_LAG_NS   = 250;
    localparam int unsigned T_DESEL_NS = 2000;
    localparam int unsigned WC_CYCLES    = T_WC_MS * CLK_KHZ;
    localparam int unsigned PUR_CYCLES   = T_PUR_MS * CLK_KHZ;
    localparam int unsigned PUW_CYCLES   = T_PUW_MS * CLK_KHZ;
    localparam int unsigned HALF_CYCLES  = (T_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LEAD_CYCLES  = (T_LEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LAG_CYCLES   = (T_LAG_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DESEL_CYCLES = (T_DESEL_NS * CLK_MHZ + 999) / 1000;

    // ----------------------------------------------------------------
    // Reset values and state types
    // ----------------------------------------------------------------
    localparam logic [2:0] SYNC_RST = 3'h0;

    typedef enum logic [0:0] {
        ST_STANDBY = 1'b0,
        ST_ACTIVE  = 1'b1
    } spw_dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_LOW  = 3'b010,
        H_HIGH = 3'b011,
        H_LAG  = 3'b100,
        H_GAP  = 3'b101
    } spw_host_state_t;
endpackage : spw_pkg

// >>> rtl/spw_link_if.sv
// The four-wire serial link between host and device, plus the output enable of the data-out pin.
// Assumes the bench joins both ends through one instance of it.
`timescale 1ns/1ps
interface spw_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe_n;
    logic so_line;

    // The idle line reads high, as a weak pull-up would make it.
    assign so_line = so_oe_n ? 1'b1 : so;

    modport device (input sck, input cs_n, input si, output so, output so_oe_n);
    modport host   (output sck, output cs_n, output si, input so_line);
endinterface : spw_link_if

// >>> rtl/spw_host.sv
// Host end: sends one frame of up to 32 bits in SPI mode 0 and captures the returned bits.
// Assumes srst_in marks the moment the device supply becomes stable.
`timescale 1ns/1ps
module spw_host #(
    parameter int unsigned PUR_CYCLES = spw_pkg::PUR_CYCLES,
    parameter int unsigned PUW_CYCLES = spw_pkg::PUW_CYCLES
) (
    // Clock, reset and enable
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    // Serial link
    spw_link_if.host         link,
    // Command request
    input  wire logic        cmd_valid_in,
    input  wire logic [31:0] cmd_frame_in,
    input  wire logic [5:0]  cmd_bits_in,
    output logic             cmd_ready_out,
    // Frame result
    output logic             done_out,
    output logic [31:0]      rx_out
);
    import spw_pkg::*;

    localparam int unsigned PUW_W = $clog2(PUW_CYCLES + 1);

    if (PUR_CYCLES < 1 || PUW_CYCLES < PUR_CYCLES || DESEL_CYCLES > 255) begin : g_bad_pu
        $error("Power-up delays must satisfy 1 <= PUR_CYCLES <= PUW_CYCLES");
    end

    // ----------------------------------------------------------------
    // Power-up gating
    // ----------------------------------------------------------------
    logic [PUW_W-1:0] pu_cnt;
    logic             pur_done;
    logic             puw_done;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pu_cnt   <= '0;
            pur_done <= 1'b0;
            puw_done <= 1'b0;
        end else if (ce_in) begin
            if (!puw_done) begin
                pu_cnt <= pu_cnt + PUW_W'(1);
            end
            if (pu_cnt == PUW_W'(PUR_CYCLES - 1)) begin
                pur_done <= 1'b1;
            end
            if (pu_cnt == PUW_W'(PUW_CYCLES - 1)) begin
                puw_done <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Data-out sampling
    // ----------------------------------------------------------------
    logic so_s1;
    logic so_s2;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            so_s1 <= 1'b1;
            so_s2 <= 1'b1;
        end else if (ce_in) begin
            so_s1 <= link.so_line;
            so_s2 <= so_s1;
        end
    end

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    spw_host_state_t state;
    logic [7:0]      tmr;
    logic [5:0]      left;
    logic [31:0]     frame;
    logic [31:0]     rx;
    logic            sck;
    logic            cs_n;
    logic            si;
    logic            ready;
    logic            done;

    wire [7:0] op_in    = cmd_frame_in[31:24];
    wire       is_wr_op = (op_in == OP_ARM) | (op_in == OP_WRITE) | (op_in == OP_WRSR);
    wire       take     = cmd_valid_in & ready & (cmd_bits_in != 6'h00) & (~is_wr_op | puw_done);
    wire       tmr_zero = (tmr == 8'h00);

    // A frame always ends with a whole bit, so the device sees a deselect only where the caller
    // placed it; bit counts that are not a byte multiple are how aborted writes are exercised.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= H_IDLE;
            tmr   <= 8'h00;
            left  <= 6'h00;
            frame <= 32'h0000_0000;
            rx    <= 32'h0000_0000;
            sck   <= 1'b0;
            cs_n  <= 1'b1;
            si    <= 1'b0;
            ready <= 1'b0;
            done  <= 1'b0;
        end else if (ce_in) begin
            done <= 1'b0;
            if (!tmr_zero) begin
                tmr <= tmr - 8'h01;
            end
            unique case (state)
                H_IDLE: begin
                    ready <= pur_done & ~take;
                    if (take) begin
                        frame <= cmd_frame_in;
                        left  <= cmd_bits_in;
                        rx    <= 32'h0000_0000;
                        cs_n  <= 1'b0;
                        si    <= cmd_frame_in[31];
                        tmr   <= 8'(LEAD_CYCLES - 1);
                        state <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (tmr_zero) begin
                        tmr   <= 8'(HALF_CYCLES - 1);
                        state <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tmr_zero) begin
                        sck   <= 1'b1;
                        rx    <= {rx[30:0], so_s2};
                        tmr   <= 8'(HALF_CYCLES - 1);
                        state <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tmr_zero) begin
                        sck  <= 1'b0;
                        left <= left - 6'h01;
                        if (left == 6'h01) begin
                            tmr   <= 8'(LAG_CYCLES - 1);
                            state <= H_LAG;
                        end else begin
                            frame <= {frame[30:0], 1'b0};
                            si    <= frame[30];
                            tmr   <= 8'(HALF_CYCLES - 1);
                            state <= H_LOW;
                        end
                    end
                end
                H_LAG: begin
                    if (tmr_zero) begin
                        cs_n  <= 1'b1;
                        si    <= 1'b0;
                        done  <= 1'b1;
                        tmr   <= 8'(DESEL_CYCLES - 1);
                        state <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (tmr_zero) begin
                        ready <= pur_done;
                        state <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    assign link.sck      = sck;
    assign link.cs_n     = cs_n;
    assign link.si       = si;
    assign cmd_ready_out = ready;
    assign done_out      = done;
    assign rx_out        = rx;
endmodule : spw_host

// >>> tb/spw_link_properties.sv
// Concurrent checks on the serial link wires and the device status outputs.
// Assumes one clk_in domain with the synchronous reset srst_in.
`timescale 1ns/1ps
module spw_link_properties #(
    parameter int unsigned WC_CYCLES = 200
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Link wires
    input wire logic sck,
    input wire logic cs_n,
    input wire logic so,
    input wire logic so_oe_n,
    // Device status
    input wire logic write_busy_out,
    input wire logic write_armed_out,
    input wire logic standby_out,
    input wire logic write_start_out
);
    // ----------------------------------------------------------------
    // Helper logic and sequences
    // ----------------------------------------------------------------
    // Counting the busy run lets one assertion judge a count too long to unroll.
    logic [31:0] busy_len;

    always_ff @(posedge clk_in) begin
        busy_len <= (srst_in || !write_busy_out) ? 32'h0 : busy_len + 32'h1;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_busy_run;
        write_busy_out [*8];
    endsequence

    sequence s_busy_end;
        $fell(write_busy_out);
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_powerup_state: assert property (
        $past(srst_in) |-> so_oe_n && standby_out && !write_armed_out && !write_busy_out)
        else $error("device not in standby state after reset");
    a_hiz_deselected: assert property (
        cs_n [*5] |-> so_oe_n && standby_out)
        else $error("data out driven or active while deselected");
    a_start_needs_arm: assert property (
        write_start_out |-> $past(write_armed_out) && !$past(write_busy_out))
        else $error("write started without the arm latch set");
    a_start_on_deselect: assert property (
        write_start_out |-> cs_n && $past(cs_n, 2))
        else $error("write started while selected");
    a_busy_with_start: assert property (
        write_start_out |-> s_busy_run)
        else $error("busy flag missing after write start");
    a_busy_length: assert property (
        s_busy_end |-> busy_len == WC_CYCLES)
        else $error("busy flag length wrong");
    a_arm_clears_end: assert property (
        s_busy_end |-> !write_armed_out)
        else $error("arm latch still set after write cycle");
    a_arm_after_frame: assert property (
        $rose(write_armed_out) |-> cs_n && $past(cs_n, 2) && !write_busy_out)
        else $error("arm latch set outside a closed frame");
    a_busy_status_out: assert property (
        write_busy_out && !so_oe_n |-> so)
        else $error("status bit low during write cycle");
    // The device moves data out a few clocks after the serial clock falls, long before it rises again.
    a_so_on_fall: assert property (
        !so_oe_n && $changed(so) |-> !sck)
        else $error("data out changed while serial clock high");
endmodule : spw_link_properties

// >>> tb/spw_eeprom_powerup_write_guard_tb_top.sv
// Bench joining host and device ends; drives the host command port and judges both ends.
// Assumes the package, interface, design ends and checker are compiled before it.
`timescale 1ns/1ps
module spi_eeprom_powerup_write_guard_tb_top;
    import spw_pkg::*;
    // ----------------------------------------------------------------
    // Signals, instances and run control
    // ----------------------------------------------------------------
    localparam int unsigned WC  = 2000;
    localparam int unsigned PUR = 50;
    localparam int unsigned PUW = 100;
    logic        clk_in       = 1'b0;
    logic        srst_in      = 1'b1;
    logic        cmd_valid_in = 1'b0;
    logic [31:0] cmd_frame_in = 32'h0;
    logic [5:0]  cmd_bits_in  = 6'h0;
    logic        cmd_ready_out;
    logic        done_out;
    logic [31:0] rx_out;
    logic        write_busy_out;
    logic        write_armed_out;
    logic        standby_out;
    logic        write_start_out;
    logic [15:0] status;
    int          err_total    = 0;
    int          compares     = 0;
    int          cycles       = 0;
    int          first_sel    = 0;

    spw_link_if link ();
    spw_device #(.WC_CYCLES(WC)) i_spw_device (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .link(link),
        .write_busy_out(write_busy_out), .write_armed_out(write_armed_out), .standby_out(standby_out),
        .write_start_out(write_start_out));
    spw_host #(.PUR_CYCLES(PUR), .PUW_CYCLES(PUW)) i_spw_host (.clk_in(clk_in), .srst_in(srst_in),
        .ce_in(1'b1), .link(link), .cmd_valid_in(cmd_valid_in), .cmd_frame_in(cmd_frame_in),
        .cmd_bits_in(cmd_bits_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out), .rx_out(rx_out));
    spw_link_properties #(.WC_CYCLES(WC)) i_spw_link_properties (.clk_in(clk_in), .srst_in(srst_in),
        .sck(link.sck), .cs_n(link.cs_n), .so(link.so), .so_oe_n(link.so_oe_n),
        .write_busy_out(write_busy_out), .write_armed_out(write_armed_out), .standby_out(standby_out),
        .write_start_out(write_start_out));

    always #4 clk_in = ~clk_in;

    // Clock count at the first select, to judge the host's power-up wait.
    always @(negedge link.cs_n) begin
        if (first_sel == 0) begin
            first_sel = cycles;
        end
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done;
        $display("compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // One whole frame; waits for the device's input synchronisers before returning.
    // Host outputs are always looked at one step after the edge that launches them.
    task automatic send(input logic [31:0] frame, input logic [5:0] bits);
        @(posedge clk_in);
        #1;
        while (cmd_ready_out !== 1'b1) begin
            @(posedge clk_in);
            #1;
        end
        cmd_frame_in = frame;
        cmd_bits_in  = bits;
        cmd_valid_in = 1'b1;
        do begin
            @(posedge clk_in);
            #1;
        end while (cmd_ready_out !== 1'b0);
        cmd_valid_in = 1'b0;
        while (done_out !== 1'b1) begin
            @(posedge clk_in);
            #1;
        end
        repeat (8) @(posedge clk_in);
        #1;
        status = rx_out[15:0];
    endtask : send

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // The write goes first, so the host still has to sit out its write power-up wait.
    task automatic t_powerup;
        @(posedge clk_in);
        #1;
        chk_flag(link.so_line, 1'b1);
        chk_flag(standby_out, 1'b1);
        chk_flag(write_armed_out, 1'b0);
        chk_flag(cmd_ready_out, 1'b0);
        send({OP_WRITE, 24'h0}, 6'h20);
        chk_flag(first_sel >= PUW, 1'b1);
        chk_flag(write_busy_out, 1'b0);
        send({OP_RDSR, 24'h0}, 6'h10);
        chk_word(status, {8'hFF, STAT_IDLE});
    endtask : t_powerup

    task automatic t_arm_codes;
        logic [7:0] ops [7] = '{OP_ARM, OP_ARM, OP_DISARM, OP_ARM, OP_ARM, OP_DISARM, OP_DISARM};
        logic [5:0] nb [7]  = '{6'h10, 6'h08, 6'h08, 6'h07, 6'h08, 6'h10, 6'h08};
        logic       ex [7]  = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 7; i++) begin
            send({ops[i], 24'h0}, nb[i]);
            chk_flag(write_armed_out, ex[i]);
            send({OP_RDSR, 24'h0}, 6'h10);
            chk_word(status, {8'hFF, ex[i] ? STAT_ARMED_MASK : STAT_IDLE});
        end
    endtask : t_arm_codes

    task automatic t_commit_counts;
        logic [7:0] ops [4] = '{OP_WRITE, OP_WRITE, OP_WRSR, OP_WRSR};
        logic [5:0] nb [4]  = '{6'h1F, 6'h20, 6'h18, 6'h10};
        logic       ex [4]  = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            send({OP_ARM, 24'h0}, 6'h08);
            send({ops[i], 24'h0}, nb[i]);
            chk_flag(write_busy_out, ex[i]);
            chk_flag(write_armed_out, 1'b1);
            if (ex[i]) begin
                send({OP_RDSR, 24'h0}, 6'h10);
                chk_word(status, {8'hFF, STAT_BUSY_ALL});
                while (write_busy_out !== 1'b0) @(posedge clk_in);
                #1;
                chk_flag(write_armed_out, 1'b0);
            end
        end
    endtask : t_commit_counts

    initial begin
        repeat (2) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        t_powerup();
        t_arm_codes();
        t_commit_counts();
        test_done();
    end
endmodule : spi_eeprom_powerup_write_guard_tb_top
